/* ipc_classifier.sv */
// Ingress priority classifier: maps each received frame header to one of
// four output queues and arbitrates those queues for the scheduler.
// Assumes header words come from the port receive logic already aligned,
// one frame per rx handshake, and that software uses AXI4-Lite.
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_classifier import ipc_pkg::*; #(
	parameter int NUM_PORTS = 8,
	parameter int PW = 3
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [PW-1:0] rx_port,
	input wire logic [15:0] rx_type0,
	input wire logic [15:0] rx_word1,
	input wire logic [15:0] rx_type1,
	input wire logic [15:0] rx_word2,
	output logic cls_valid,
	input wire logic cls_ready,
	output logic [PW-1:0] cls_port,
	output ipc_level_t cls_level,
	input wire logic [3:0] sch_nonempty,
	input wire logic sch_req,
	output logic sch_grant_valid,
	output logic [1:0] sch_grant_queue
);

	// ============================================================
	// Configuration state
	ipc_ptype_t ptype;
	logic strict_policy;
	ipc_level_t port_lvl [NUM_PORTS];
	ipc_level_t up_lvl [8];
	logic [31:0] frame_count;

	// ============================================================
	// Bus slave state
	logic aw_held;
	logic [11:0] aw_addr;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	logic wr_ok;
	logic rd_busy;
	logic [11:0] rd_addr;

	// ============================================================
	// Pipeline state
	logic rx_fire;
	logic s1_valid;
	logic s1_adv;
	logic [PW-1:0] s1_port;
	logic s1_tagged;
	logic s1_is_ip;
	logic [2:0] s1_up;
	logic rx_tagged;
	logic [15:0] rx_inner_type;
	logic [15:0] rx_ip_word;
	logic rx_is_ip;
	logic [5:0] rx_dscp;
	ipc_level_t ip_level;
	ipc_level_t dscp_bus_level;
	ipc_level_t next_level;

	// ============================================================
	// Scheduler state
	logic [3:0] credit [4];
	logic [3:0] has_credit;
	logic [3:0] eligible;
	logic [1:0] pick_elig;
	logic [1:0] pick_any;
	logic any_elig;
	logic any_ne;
	logic grant_now;
	logic reload;
	logic [1:0] next_grant;

	// ============================================================
	// Write channel: address and data are taken in either order.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_do = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_do) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		wr_ok = 1'b1;
		if (aw_addr[11:8] == `IPC_DSCP_PAGE) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `IPC_ADDR_CTRL) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `IPC_ADDR_PORT_MAP) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `IPC_ADDR_UP_MAP) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `IPC_ADDR_STATUS) begin
			wr_ok = 1'b1;
		end else if (aw_addr == `IPC_ADDR_COUNT) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IPC_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ============================================================
	// Control register; codes beyond tag-first behave as disable.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ptype <= ipc_ptype_t'(`IPC_CTRL_RESET);
			strict_policy <= 1'b0;
		end else if (wr_do && aw_addr == `IPC_ADDR_CTRL && w_strb[0]) begin
			ptype <= ipc_ptype_t'(w_data[`IPC_CTRL_PTYPE_LSB +: 3]);
			strict_policy <= w_data[`IPC_CTRL_POLICY_BIT];
		end
	end

	// Per-port and per-user-priority tables, two bits per entry.
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				port_lvl[p] <= IPC_LOWEST;
			end else if (wr_do && aw_addr == `IPC_ADDR_PORT_MAP &&
				w_strb[p/4]) begin
				port_lvl[p] <= ipc_level_t'(w_data[2*p +: 2]);
			end
		end
	end

	for (genvar u = 0; u < 8; u++) begin : g_up
		localparam logic [15:0] UP_RST = `IPC_UP_MAP_RESET;
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				up_lvl[u] <= ipc_level_t'(UP_RST[2*u +: 2]);
			end else if (wr_do && aw_addr == `IPC_ADDR_UP_MAP &&
				w_strb[u/4]) begin
				up_lvl[u] <= ipc_level_t'(w_data[2*u +: 2]);
			end
		end
	end

	// ============================================================
	// Codepoint table
	ipc_dscp_map #(
		.ENTRIES(64),
		.AW(6)
	) u_dscp_map (
		.clk_sys(clk_sys),
		.reset(reset),
		.wr_en(wr_do && aw_addr[11:8] == `IPC_DSCP_PAGE && w_strb[0]),
		.wr_addr(aw_addr[7:2]),
		.wr_level(ipc_level_t'(w_data[1:0])),
		.a_en(rx_fire),
		.a_addr(rx_dscp),
		.a_data(ip_level),
		.b_en(s_axi_arvalid && s_axi_arready),
		.b_addr(s_axi_araddr[7:2]),
		.b_data(dscp_bus_level)
	);

	// ============================================================
	// Read channel: every read answers on the second edge after it is
	// taken, because table reads come out of a registered port.
	assign s_axi_arready = !rd_busy && !s_axi_rvalid;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_busy <= 1'b0;
			rd_addr <= 12'h000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_busy <= 1'b1;
			rd_addr <= s_axi_araddr;
		end else begin
			rd_busy <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `IPC_RESP_OKAY;
		end else if (rd_busy) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `IPC_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (rd_addr[11:8] == `IPC_DSCP_PAGE) begin
				s_axi_rdata[1:0] <= dscp_bus_level;
			end else if (rd_addr == `IPC_ADDR_CTRL) begin
				s_axi_rdata[`IPC_CTRL_PTYPE_LSB +: 3] <= ptype;
				s_axi_rdata[`IPC_CTRL_POLICY_BIT] <= strict_policy;
			end else if (rd_addr == `IPC_ADDR_PORT_MAP) begin
				for (int p = 0; p < NUM_PORTS; p++) begin
					s_axi_rdata[2*p +: 2] <= port_lvl[p];
				end
			end else if (rd_addr == `IPC_ADDR_UP_MAP) begin
				for (int u = 0; u < 8; u++) begin
					s_axi_rdata[2*u +: 2] <= up_lvl[u];
				end
			end else if (rd_addr == `IPC_ADDR_STATUS) begin
				s_axi_rdata[`IPC_STAT_LEVEL_LSB +: 2] <= cls_level;
				s_axi_rdata[`IPC_STAT_BUSY_BIT] <= s1_valid;
				s_axi_rdata[`IPC_STAT_OUT_BIT] <= cls_valid;
				s_axi_rdata[`IPC_STAT_GRANT_LSB +: 2] <= sch_grant_queue;
			end else if (rd_addr == `IPC_ADDR_COUNT) begin
				s_axi_rdata <= frame_count;
			end else begin
				s_axi_rresp <= `IPC_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ============================================================
	// Header parse. Untagged frames carry the IP header start in word1;
	// tagged ones carry the tag control word there and the IP start in
	// word2.
	assign rx_tagged = (rx_type0 == `IPC_TYPE_VLAN);
	assign rx_inner_type = rx_tagged ? rx_type1 : rx_type0;
	assign rx_ip_word = rx_tagged ? rx_word2 : rx_word1;
	assign rx_is_ip = (rx_inner_type == `IPC_TYPE_IPV4) &&
		(rx_ip_word[15:12] == `IPC_IPV4_VERSION);
	assign rx_dscp = rx_ip_word[7:2];

	// A one-deep stage feeds the output register; the table read lands
	// with the stage so both stall together.
	assign s1_adv = s1_valid && (!cls_valid || cls_ready);
	assign rx_ready = !s1_valid || s1_adv;
	assign rx_fire = rx_valid && rx_ready;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s1_valid <= 1'b0;
			s1_port <= '0;
			s1_tagged <= 1'b0;
			s1_is_ip <= 1'b0;
			s1_up <= 3'h0;
		end else if (rx_fire) begin
			s1_valid <= 1'b1;
			s1_port <= rx_port;
			s1_tagged <= rx_tagged;
			s1_is_ip <= rx_is_ip;
			s1_up <= rx_word1[15:13];
		end else if (s1_adv) begin
			s1_valid <= 1'b0;
		end
	end

	// ============================================================
	// Level selection by priority type.
	always_comb begin
		next_level = IPC_LOWEST;
		case (ptype)
			IPC_PT_PORT: begin
				next_level = port_lvl[s1_port];
			end
			IPC_PT_TAG_ONLY: begin
				if (s1_tagged) begin
					next_level = up_lvl[s1_up];
				end
			end
			IPC_PT_IP_ONLY: begin
				if (s1_is_ip) begin
					next_level = ip_level;
				end
			end
			IPC_PT_TAG_FIRST: begin
				if (s1_tagged) begin
					next_level = up_lvl[s1_up];
				end else if (s1_is_ip) begin
					next_level = ip_level;
				end
			end
			IPC_PT_IP_FIRST: begin
				if (s1_is_ip) begin
					next_level = ip_level;
				end else if (s1_tagged) begin
					next_level = up_lvl[s1_up];
				end
			end
			default: begin
				next_level = IPC_LOWEST;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cls_valid <= 1'b0;
			cls_port <= '0;
			cls_level <= IPC_LOWEST;
		end else if (s1_adv) begin
			cls_valid <= 1'b1;
			cls_port <= s1_port;
			cls_level <= next_level;
		end else if (cls_ready) begin
			cls_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			frame_count <= 32'h0000_0000;
		end else if (s1_adv) begin
			frame_count <= frame_count + 32'h0000_0001;
		end
	end

	// ============================================================
	// Queue arbitration. Queue index equals level code, 3 is High.
	// Weighted mode spends credits from the highest eligible queue and
	// refills all credits only once no backlogged queue has any left, so
	// an idle queue never blocks a round.
	always_comb begin
		any_elig = 1'b0;
		any_ne = 1'b0;
		pick_elig = 2'd0;
		pick_any = 2'd0;
		for (int q = 0; q < 4; q++) begin
			eligible[q] = sch_nonempty[q] && has_credit[q];
			if (eligible[q]) begin
				any_elig = 1'b1;
				pick_elig = q[1:0];
			end
			if (sch_nonempty[q]) begin
				any_ne = 1'b1;
				pick_any = q[1:0];
			end
		end
	end

	assign grant_now = sch_req && any_ne;
	assign reload = grant_now && !strict_policy && !any_elig;
	assign next_grant = (strict_policy || !any_elig) ? pick_any : pick_elig;

	for (genvar q = 0; q < 4; q++) begin : g_credit
		localparam logic [3:0] WEIGHT = (q == 3) ? `IPC_WEIGHT_HIGH :
			(q == 2) ? `IPC_WEIGHT_MIDDLE :
			(q == 1) ? `IPC_WEIGHT_LOW : `IPC_WEIGHT_LOWEST;
		assign has_credit[q] = (credit[q] != 4'h0);
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				credit[q] <= WEIGHT;
			end else if (reload) begin
				credit[q] <= (next_grant == 2'(q)) ? WEIGHT - 4'h1 :
					WEIGHT;
			end else if (grant_now && !strict_policy &&
				next_grant == 2'(q)) begin
				credit[q] <= credit[q] - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sch_grant_valid <= 1'b0;
			sch_grant_queue <= 2'd0;
		end else begin
			sch_grant_valid <= grant_now;
			if (grant_now) begin
				sch_grant_queue <= next_grant;
			end
		end
	end

endmodule : ipc_classifier

/* ipc_params.svh */
// Offsets, field positions, reset values and codes for the ingress priority
// classifier. Included by the design files; holds definitions only.
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// ============================================================
// Register byte offsets
`define IPC_ADDR_CTRL 12'h000
`define IPC_ADDR_PORT_MAP 12'h004
`define IPC_ADDR_UP_MAP 12'h008
`define IPC_ADDR_STATUS 12'h00c
`define IPC_ADDR_COUNT 12'h010
`define IPC_DSCP_PAGE 4'h1

// ============================================================
// Field positions and reset values
`define IPC_CTRL_PTYPE_LSB 0
`define IPC_CTRL_POLICY_BIT 3
`define IPC_CTRL_RESET 4'h0
`define IPC_UP_MAP_RESET 16'hfa50
`define IPC_STAT_LEVEL_LSB 0
`define IPC_STAT_BUSY_BIT 2
`define IPC_STAT_OUT_BIT 3
`define IPC_STAT_GRANT_LSB 4

// ============================================================
// Bus answers
`define IPC_RESP_OKAY 2'b00
`define IPC_RESP_SLVERR 2'b10

// ============================================================
// Frame header codes
`define IPC_TYPE_VLAN 16'h8100
`define IPC_TYPE_IPV4 16'h0800
`define IPC_IPV4_VERSION 4'h4

// ============================================================
// Weighted round credits, High down to Lowest
`define IPC_WEIGHT_HIGH 4'h8
`define IPC_WEIGHT_MIDDLE 4'h4
`define IPC_WEIGHT_LOW 4'h2
`define IPC_WEIGHT_LOWEST 4'h1

`endif

/* ipc_pkg.sv */
// Types shared by the ingress priority classifier files.
// Assumes nothing of its surroundings.
package ipc_pkg;

	// ============================================================
	// Queue levels; Lowest is all zeros so a cleared table means Lowest.
	typedef enum logic [1:0] {
		IPC_LOWEST = 2'b00,
		IPC_LOW = 2'b01,
		IPC_MIDDLE = 2'b10,
		IPC_HIGH = 2'b11
	} ipc_level_t;

	// ============================================================
	// Priority type selections.
	typedef enum logic [2:0] {
		IPC_PT_DISABLE = 3'h0,
		IPC_PT_PORT = 3'h1,
		IPC_PT_IP_ONLY = 3'h2,
		IPC_PT_TAG_ONLY = 3'h3,
		IPC_PT_IP_FIRST = 3'h4,
		IPC_PT_TAG_FIRST = 3'h5
	} ipc_ptype_t;

endpackage : ipc_pkg

/* ipc_dscp_map.sv */
// Codepoint-to-level table with one write port and two registered read
// ports. Assumes a single synchronous clock and an active-high reset.
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_dscp_map import ipc_pkg::*; #(
	parameter int ENTRIES = 64,
	parameter int AW = 6
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire ipc_level_t wr_level,
	input wire logic a_en,
	input wire logic [AW-1:0] a_addr,
	output ipc_level_t a_data,
	input wire logic b_en,
	input wire logic [AW-1:0] b_addr,
	output ipc_level_t b_data
);

	ipc_level_t mem [ENTRIES];

	// ============================================================
	// Storage
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < ENTRIES; i++) begin
				mem[i] <= IPC_LOWEST;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_level;
		end
	end

	// ============================================================
	// Read ports hold their data while not enabled.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			a_data <= IPC_LOWEST;
		end else if (a_en) begin
			a_data <= mem[a_addr];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			b_data <= IPC_LOWEST;
		end else if (b_en) begin
			b_data <= mem[b_addr];
		end
	end

endmodule : ipc_dscp_map

/* ipc_chk_props.sv */
// Port-level assertions for the ingress priority classifier.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module ipc_chk import ipc_pkg::*; #(
	parameter int PW = 3
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cls_valid,
	input wire logic cls_ready,
	input wire logic [PW-1:0] cls_port,
	input wire ipc_level_t cls_level,
	input wire logic [3:0] sch_nonempty,
	input wire logic sch_req,
	input wire logic sch_grant_valid,
	input wire logic [1:0] sch_grant_queue
);
	// ============================================================
	// Bus, frame and grant relations
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two cycles after request");
	a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=>
		!s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer not two cycles after request");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &&
		!s_axi_wready) else $error("write accepted while answer pending");
	a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answer pending");
	a_cls_hold: assert property (
		cls_valid && !cls_ready |=> cls_valid && $stable(cls_level) &&
		$stable(cls_port)) else $error("class result changed while stalled");
	a_grant_due: assert property (
		sch_req && sch_nonempty != 4'h0 |=> sch_grant_valid)
		else $error("no grant with a queue backlogged");
	a_grant_none: assert property (!sch_req || sch_nonempty == 4'h0 |=>
		!sch_grant_valid) else $error("grant without a request");
	a_grant_busy: assert property (
		sch_grant_valid |-> (($past(sch_nonempty) >> sch_grant_queue) &
		4'h1) != 4'h0) else $error("grant to an empty queue");

	c_frame: cover property (cls_valid && cls_ready);
	c_grant: cover property (sch_grant_valid);
	c_stall: cover property (cls_valid && !cls_ready ##1 cls_ready);
endmodule : ipc_chk

bind ipc_classifier ipc_chk #(.PW(PW)) u_chk (.*);

/* ipc_peer.sv */
// Far-side model: port receive logic feeding frame headers and a queue
// intake taking results. Assumes send is called right after a clock edge.
`timescale 1ns/1ps
module ipc_peer import ipc_pkg::*; (
	input wire logic clk_sys,
	input wire logic stall,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [2:0] rx_port,
	output logic [15:0] rx_type0,
	output logic [15:0] rx_word1,
	output logic [15:0] rx_type1,
	output logic [15:0] rx_word2,
	input wire logic cls_valid,
	output logic cls_ready,
	input wire logic [2:0] cls_port,
	input wire ipc_level_t cls_level
);
	logic [4:0] got_q[$];

	assign cls_ready = !stall;
	initial begin
		rx_valid = 1'b0;
		rx_port = 3'h0;
		{rx_type0, rx_word1, rx_type1, rx_word2} = 64'h0;
	end
	always @(posedge clk_sys) begin
		if (cls_valid && cls_ready)
			got_q.push_back({cls_port, cls_level});
	end
	// Released header lines flip so a stale header never looks current.
	task send(input logic [2:0] p, input logic [63:0] h, input logic more);
		rx_port <= p;
		{rx_type0, rx_word1, rx_type1, rx_word2} <= h;
		rx_valid <= 1'b1;
		do @(negedge clk_sys); while (!rx_ready);
		@(posedge clk_sys);
		if (!more) begin
			rx_valid <= 1'b0;
			{rx_type0, rx_word1, rx_type1, rx_word2} <= ~h;
		end
	endtask : send
endmodule : ipc_peer

/* tb_top.sv */
// Self-checking bench: registers over AXI4-Lite, frames through the peer
// model, grants from the scheduler side. Assumes the design's defaults.
`timescale 1ns/1ps
`include "ipc_params.svh"
module tb_top import ipc_pkg::*; ;
	logic clk_sys, reset, stall, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, rx_valid, rx_ready, cls_valid, cls_ready;
	logic sch_req, sch_grant_valid, s_axi_bready, s_axi_rready;
	logic [3:0] s_axi_wstrb, sch_nonempty;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, sch_grant_queue;
	logic [2:0] rx_port, cls_port;
	logic [15:0] rx_type0, rx_word1, rx_type1, rx_word2;
	ipc_level_t cls_level;
	int error_cnt, samples_checked;
	logic [15:0] pm, um;

	ipc_classifier u_dut (.*);
	ipc_peer u_peer (.*);

	// ============================================================
	// Shared tasks
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		logic pa, pw, ta, tw;
		pa = 1'b0;
		pw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(pa && pw)) begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			pa = pa | ta;
			pw = pw | tw;
		end
		do @(negedge clk_sys); while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'(e));
		@(posedge clk_sys);
	endtask : wr

	task rc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge clk_sys); while (!s_axi_arready);
		@(posedge clk_sys);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk_sys); while (!s_axi_rvalid);
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
		@(posedge clk_sys);
	endtask : rc

	// One frame: tagged or not, IPv4 or not, user priority, codepoint.
	task fr(input logic [2:0] p, input logic tg, input logic ip,
		input logic [2:0] u, input logic [5:0] d, input ipc_level_t e);
		logic [15:0] iw, ty;
		iw = {8'h45, d, 2'b00};
		ty = ip ? `IPC_TYPE_IPV4 : 16'h88b5;
		if (tg) u_peer.send(p, {`IPC_TYPE_VLAN, u, 13'h0, ty, iw}, 1'b0);
		else u_peer.send(p, {ty, iw, 32'h0}, 1'b0);
		while (u_peer.got_q.size() == 0) @(posedge clk_sys);
		chk(32'(u_peer.got_q.pop_front()), 32'({p, e}));
	endtask : fr

	task gr(input logic [3:0] ne, input logic [1:0] q);
		sch_nonempty <= ne;
		sch_req <= 1'b1;
		@(posedge clk_sys);
		sch_req <= 1'b0;
		@(negedge clk_sys);
		chk(32'({sch_grant_valid, sch_grant_queue}), 32'({ne != 4'h0, q}));
		@(posedge clk_sys);
	endtask : gr

	// ============================================================
	// Scenarios
	task t_regs;
		rc(`IPC_ADDR_CTRL, 32'h0, `IPC_RESP_OKAY);
		rc(`IPC_ADDR_UP_MAP, 32'(`IPC_UP_MAP_RESET), `IPC_RESP_OKAY);
		rc({`IPC_DSCP_PAGE, 8'h00}, 32'h0, `IPC_RESP_OKAY);
		rc({`IPC_DSCP_PAGE, 8'hfc}, 32'h0, `IPC_RESP_OKAY);
		rc(12'h020, 32'h0, `IPC_RESP_SLVERR);
		wr(12'h020, 32'h3, `IPC_RESP_SLVERR);
		wr(`IPC_ADDR_PORT_MAP, 32'(pm), `IPC_RESP_OKAY);
	endtask : t_regs

	task t_modes;
		for (int m = 0; m < 3; m++) begin
			wr(`IPC_ADDR_CTRL, (m == 0) ? 32'h0 : 32'(m + 5), `IPC_RESP_OKAY);
			fr(3'h1, 1'b1, 1'b1, 3'h7, 6'h19, IPC_LOWEST);
		end
	endtask : t_modes

	task t_port;
		wr(`IPC_ADDR_CTRL, 32'h1, `IPC_RESP_OKAY);
		for (int p = 0; p < 8; p++)
			fr(3'(p), 1'b1, 1'b1, 3'h7, 6'h19, ipc_level_t'(pm[2*p+:2]));
		wr(`IPC_ADDR_CTRL, 32'h3, `IPC_RESP_OKAY);
		fr(3'h1, 1'b0, 1'b1, 3'h0, 6'h19, IPC_LOWEST);
	endtask : t_port

	task t_tag;
		fr(3'h0, 1'b1, 1'b0, 3'h7, 6'h0, IPC_HIGH);
		fr(3'h0, 1'b1, 1'b0, 3'h0, 6'h0, IPC_LOWEST);
		wr(`IPC_ADDR_UP_MAP, 32'(um), `IPC_RESP_OKAY);
		for (int u = 0; u < 8; u++)
			fr(3'h2, 1'b1, 1'b0, 3'(u), 6'h0, ipc_level_t'(um[2*u+:2]));
	endtask : t_tag

	task t_ip;
		wr({`IPC_DSCP_PAGE, 6'h19, 2'b00}, 32'h3, `IPC_RESP_OKAY);
		wr({`IPC_DSCP_PAGE, 6'h3f, 2'b00}, 32'h2, `IPC_RESP_OKAY);
		fr(3'h3, 1'b0, 1'b1, 3'h0, 6'h19, IPC_LOWEST);
		wr(`IPC_ADDR_CTRL, 32'h2, `IPC_RESP_OKAY);
		fr(3'h3, 1'b0, 1'b1, 3'h0, 6'h19, IPC_HIGH);
		fr(3'h3, 1'b1, 1'b1, 3'h0, 6'h3f, IPC_MIDDLE);
		fr(3'h3, 1'b1, 1'b1, 3'h0, 6'h05, IPC_LOWEST);
		fr(3'h3, 1'b0, 1'b0, 3'h0, 6'h19, IPC_LOWEST);
		fr(3'h3, 1'b1, 1'b0, 3'h3, 6'h0, IPC_LOWEST);
	endtask : t_ip

	task t_first;
		wr(`IPC_ADDR_CTRL, 32'h5, `IPC_RESP_OKAY);
		fr(3'h4, 1'b1, 1'b1, 3'h3, 6'h3f, IPC_HIGH);
		fr(3'h4, 1'b0, 1'b1, 3'h0, 6'h3f, IPC_MIDDLE);
		fr(3'h4, 1'b0, 1'b0, 3'h0, 6'h19, IPC_LOWEST);
		wr(`IPC_ADDR_CTRL, 32'h4, `IPC_RESP_OKAY);
		fr(3'h4, 1'b1, 1'b1, 3'h3, 6'h3f, IPC_MIDDLE);
		fr(3'h4, 1'b1, 1'b0, 3'h1, 6'h19, IPC_LOW);
		fr(3'h4, 1'b0, 1'b0, 3'h0, 6'h0, IPC_LOWEST);
	endtask : t_first

	// Two frames back to back while the queue intake stalls.
	task t_back;
		wr(`IPC_ADDR_CTRL, 32'h1, `IPC_RESP_OKAY);
		stall <= 1'b1;
		u_peer.send(3'h4, {16'h88b5, 48'h0}, 1'b1);
		u_peer.send(3'h5, {16'h88b5, 48'h0}, 1'b0);
		repeat (6) @(posedge clk_sys);
		chk(32'(u_peer.got_q.size()), 32'h0);
		stall <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(32'(u_peer.got_q.pop_front()), 32'({3'h4, pm[9:8]}));
		chk(32'(u_peer.got_q.pop_front()), 32'({3'h5, pm[11:10]}));
		rc(`IPC_ADDR_STATUS, 32'h33, `IPC_RESP_OKAY);
		rc(`IPC_ADDR_COUNT, 32'h24, `IPC_RESP_OKAY);
	endtask : t_back

	task t_sched;
		int c[4];
		c = '{0, 0, 0, 0};
		wr(`IPC_ADDR_CTRL, 32'h0, `IPC_RESP_OKAY);
		sch_nonempty <= 4'hf;
		sch_req <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			@(negedge clk_sys);
			if (sch_grant_valid === 1'b1) c[sch_grant_queue]++;
			@(posedge clk_sys);
			if (i == 14) sch_req <= 1'b0;
		end
		for (int q = 0; q < 4; q++) chk(32'(c[q]), 32'(1 << q));
		wr(`IPC_ADDR_CTRL, 32'h8, `IPC_RESP_OKAY);
		gr(4'b0110, 2'h2);
		gr(4'b0011, 2'h1);
		gr(4'b1001, 2'h3);
		gr(4'b0000, 2'h3);
	endtask : t_sched

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// ============================================================
	// Clock, watchdog and main sequence
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#500000;
		error_cnt++;
		final_report();
	end
	initial begin
		{error_cnt, samples_checked} = '0;
		{reset, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
		{stall, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sch_req} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sch_nonempty} = '0;
		pm = 16'h4e1b;
		um = 16'h1be4;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_sched();
		t_modes();
		t_port();
		t_tag();
		t_ip();
		t_first();
		t_back();
		final_report();
	end
endmodule : tb_top
